// [src/icst_pkg.sv]
package icst_pkg;

  // timing of the system clock and the slow reference clock
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned BASE_FREQ_HZ    = 307_200;
  localparam int unsigned BASE_PERIOD_CYC = CLK_HZ / BASE_FREQ_HZ; // nominal period at 512 units, rounds down

  // base clock timing capacitor, in units
  localparam logic [9:0] CAP_FIXED_UNITS = 10'h180;
  localparam logic [9:0] CAP_NOMINAL     = 10'h200;

  // register reset values
  localparam logic [6:0] MULT_RESET  = 7'h15;
  localparam logic [7:0] TRIM_RESET  = 8'h80;
  localparam logic [3:0] DIV_RESET   = 4'h0;
  localparam logic [7:0] STAGE_RESET = 8'h80;
  localparam logic [3:0] DIV_MAX     = 4'h9;

  // loop filter step sizes on the stage control
  localparam logic [7:0] STEP_COARSE = 8'h20;
  localparam logic [7:0] STEP_MEDIUM = 8'h04;
  localparam logic [7:0] STEP_MIN    = 8'h01;
  localparam logic [7:0] STAGE_HALF  = 8'h80;
  localparam logic [7:0] STAGE_FLOOR = 8'h01;
  localparam logic [7:0] STAGE_TOP   = 8'hFF;

  // one measurement spans four slow reference periods
  localparam logic [1:0] MEAS_LAST_PERIOD = 2'h3;
  // ring ticks are half periods: 4 base periods x 2 = 8 ticks per unit of multiply
  localparam int unsigned TARGET_SHIFT    = 3;
  // error bands: err*20 > target*3 is above 15 %, err*20 > target is above 5 %
  localparam logic [23:0] ERR_SCALE  = 24'h000014;
  localparam logic [23:0] BAND_15PCT = 24'h000003;
  localparam logic [23:0] BAND_5PCT  = 24'h000001;

  // bus clock is the ring clock divided by four: toggle every 4 half periods
  localparam logic [1:0] BUS_TOGGLE_LAST = 2'h3;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MULT   = 8'h04;
  localparam logic [7:0] ADDR_TRIM   = 8'h08;
  localparam logic [7:0] ADDR_DIV    = 8'h0C;
  localparam logic [7:0] ADDR_STAGE  = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_MEAS   = 8'h18;

  typedef enum logic [1:0] {BAND_MIN, BAND_MEDIUM, BAND_COARSE} icst_band_t;
  typedef enum logic [1:0] {FLT_IDLE, FLT_MEASURE, FLT_CORRECT} icst_flt_state_t;

  typedef struct packed {
    logic       gen_on;
    logic [6:0] mult;
    logic [7:0] trim;
  } icst_cfg_t;

  typedef struct packed {
    logic [3:0] div;
    logic [7:0] stage;
  } icst_dco_t;

endpackage : icst_pkg

// [src/icst_base_clk.sv]
`timescale 1ns/1ps
// slow reference clock: period grows with the connected capacitor units
module icst_base_clk (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [7:0] trim,
  output logic            tick
);

  logic [16:0] acc;
  logic [16:0] next_acc;
  logic        next_tick;
  logic [16:0] thr;
  logic [16:0] sum;

  // threshold in nominal units: (384 + trim) * base period; 512 gives the nominal rate
  always_comb begin
    thr       = 17'((17'(icst_pkg::CAP_FIXED_UNITS) + 17'(trim))
                    * 17'(icst_pkg::BASE_PERIOD_CYC));
    sum       = acc + 17'(icst_pkg::CAP_NOMINAL);
    next_acc  = acc;
    next_tick = 1'b0;
    if (!run) begin
      next_acc = '0;
    end else if (sum >= thr) begin
      next_acc  = sum - thr;
      next_tick = 1'b1;
    end else begin
      next_acc = sum;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc  <= '0;
      tick <= 1'b0;
    end else begin
      acc  <= next_acc;
      tick <= next_tick;
    end
  end

endmodule : icst_base_clk

// [src/icst_ring_osc.sv]
`timescale 1ns/1ps
// ring oscillator model: period proportional to stage << divider
module icst_ring_osc #(
  parameter logic [17:0] RING_UNIT = 18'h00020
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic                  run,
  input  wire icst_pkg::icst_dco_t   dco,
  output logic                       tick,
  output logic                       level
);

  logic [17:0] acc;
  logic [17:0] next_acc;
  logic        next_tick;
  logic        next_level;
  logic [3:0]  div_eff;
  logic [17:0] thr;
  logic [17:0] sum;

  // divider codes above nine act as nine; stage zero acts as one
  always_comb begin
    div_eff    = (dco.div > icst_pkg::DIV_MAX) ? icst_pkg::DIV_MAX : dco.div;
    thr        = 18'((dco.stage == '0) ? icst_pkg::STAGE_FLOOR : dco.stage) << div_eff;
    sum        = acc + RING_UNIT;
    next_acc   = acc;
    next_tick  = 1'b0;
    next_level = level;
    if (!run) begin
      next_acc   = '0;
      next_level = 1'b0;
    end else if (sum >= thr) begin
      next_acc   = sum - thr;
      next_tick  = 1'b1;
      next_level = ~level;
    end else begin
      next_acc = sum;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc   <= '0;
      tick  <= 1'b0;
      level <= 1'b0;
    end else begin
      acc   <= next_acc;
      tick  <= next_tick;
      level <= next_level;
    end
  end

endmodule : icst_ring_osc

// [src/icst_clock_gen.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - medium band steps about two percent, eight max
// - each correction spans four slow reference periods
// - stable flag sets within five percent error
// - minimum band steps a fraction percent, 24 max
// - divider and stage writable only while off
// - restart uses last written divider and stage
// - period follows two to divider times stage
// - capacitor is 384 fixed plus trim units
// - trim resets to 128, capacitor 512 units
// - each trim unit shifts rate 0.195 percent
// - bus clock is base times multiply over four
// - wait mode leaves the generator running
// - stop mode halts all clocks and holds them low
// - stop mode leaves register contents untouched
// - divider codes above nine act as nine
// - ring rate is multiply times slow reference
// - coarse steps above fifteen percent, eight double
// - writing multiply clears the stable flag
module icst_clock_gen #(
  parameter logic [17:0] RING_UNIT = 18'h00020
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  output logic             ring_clock,
  output logic             selected_osc_output,
  output logic             bus_clock_output,
  output logic             clock_stable_flag
);

  icst_pkg::icst_cfg_t       cfg;
  icst_pkg::icst_cfg_t       next_cfg;
  icst_pkg::icst_dco_t       dco;
  icst_pkg::icst_dco_t       next_dco;
  logic                      stable;
  logic                      next_stable;
  icst_pkg::icst_flt_state_t state;
  icst_pkg::icst_flt_state_t next_state;
  logic [1:0]                win_cnt;
  logic [1:0]                next_win_cnt;
  logic [15:0]               ring_cnt;
  logic [15:0]               next_ring_cnt;
  logic [15:0]               meas;
  logic [15:0]               next_meas;
  icst_pkg::icst_band_t      band;
  icst_pkg::icst_band_t      next_band;
  logic [1:0]                bus_cnt;
  logic [1:0]                next_bus_cnt;
  logic                      bus_lvl;
  logic                      next_bus_lvl;
  logic [31:0]               rdata;
  logic [31:0]               next_rdata;

  logic                      run;
  logic                      base_tick;
  logic                      ring_tick;
  logic                      ring_lvl;
  logic                      wr_en;
  logic                      rd_setup;
  logic                      mapped;
  logic                      wr_mult;
  logic                      wr_trim;
  logic [15:0]               target;
  logic [15:0]               err;
  logic                      too_fast;
  logic [23:0]               err_scaled;
  icst_pkg::icst_band_t      meas_band;
  logic [7:0]                step;

  // stop halts both oscillators, the window count and dco corrections; wait mode has no effect on the generator
  assign run = cfg.gen_on & ~stop_mode;

  // a multiply or trim write restarts the base phase, so no window is ever partial
  icst_base_clk u_base (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (run & ~(wr_mult | wr_trim)),
    .trim    (cfg.trim),
    .tick    (base_tick)
  );

  icst_ring_osc #(
    .RING_UNIT (RING_UNIT)
  ) u_ring (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (run),
    .dco     (dco),
    .tick    (ring_tick),
    .level   (ring_lvl)
  );

  // apb decode: zero wait states, errors on unmapped addresses
  always_comb begin
    case (paddr)
      icst_pkg::ADDR_CTRL,
      icst_pkg::ADDR_MULT,
      icst_pkg::ADDR_TRIM,
      icst_pkg::ADDR_DIV,
      icst_pkg::ADDR_STAGE,
      icst_pkg::ADDR_STATUS,
      icst_pkg::ADDR_MEAS:  mapped = 1'b1;
      default:              mapped = 1'b0;
    endcase
  end

  assign wr_en    = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_mult  = wr_en & (paddr == icst_pkg::ADDR_MULT);
  assign wr_trim  = wr_en & (paddr == icst_pkg::ADDR_TRIM);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  // error of the last measurement against multiply x ticks per base window
  always_comb begin
    target     = 16'(cfg.mult) << icst_pkg::TARGET_SHIFT;
    too_fast   = meas > target;
    err        = too_fast ? (meas - target) : (target - meas);
    err_scaled = 24'(err) * icst_pkg::ERR_SCALE;
    if (err_scaled > 24'(target) * icst_pkg::BAND_15PCT) begin
      meas_band = icst_pkg::BAND_COARSE;
      step      = icst_pkg::STEP_COARSE;
    end else if (err_scaled > 24'(target) * icst_pkg::BAND_5PCT) begin
      meas_band = icst_pkg::BAND_MEDIUM;
      step      = icst_pkg::STEP_MEDIUM;
    end else begin
      meas_band = icst_pkg::BAND_MIN;
      step      = icst_pkg::STEP_MIN;
    end
  end

  // stage step with carry into the divider; a borrow lowers div when the stage falls below half
  function automatic icst_pkg::icst_dco_t dco_step(
    input icst_pkg::icst_dco_t cur,
    input logic [7:0]          amount,
    input logic                longer
  );
    icst_pkg::icst_dco_t res;
    logic [8:0]          sum;
    logic [7:0]          diff;
    logic [3:0]          div_eff;
    res     = cur;
    sum     = {1'b0, cur.stage} + {1'b0, amount};
    diff    = cur.stage - amount;
    div_eff = (cur.div > icst_pkg::DIV_MAX) ? icst_pkg::DIV_MAX : cur.div;
    if (longer) begin
      if (!sum[8]) begin
        res.stage = sum[7:0];
      end else if (div_eff < icst_pkg::DIV_MAX) begin
        res.div   = div_eff + 4'h1;
        res.stage = sum[8:1];
      end else begin
        res.stage = icst_pkg::STAGE_TOP;
      end
    end else begin
      if (cur.stage <= amount) begin
        res.stage = icst_pkg::STAGE_FLOOR;
      end else if (diff < icst_pkg::STAGE_HALF && div_eff != 4'h0) begin
        res.div   = div_eff - 4'h1;
        res.stage = {diff[6:0], 1'b0};
      end else begin
        res.stage = diff;
      end
    end
    return res;
  endfunction : dco_step

  // loop filter sequencing: measure over four base periods, then correct once
  always_comb begin
    next_state    = state;
    next_win_cnt  = win_cnt;
    next_ring_cnt = ring_cnt;
    next_meas     = meas;
    next_band     = band;
    case (state)
      icst_pkg::FLT_IDLE: begin
        next_win_cnt  = '0;
        next_ring_cnt = '0;
        if (run) begin
          next_state = icst_pkg::FLT_MEASURE;
        end
      end
      icst_pkg::FLT_MEASURE: begin
        if (!cfg.gen_on) begin
          next_state = icst_pkg::FLT_IDLE;
        end else if (wr_mult || wr_trim) begin
          // discard a window that straddles an operating point change
          next_win_cnt  = '0;
          next_ring_cnt = '0;
        end else if (run) begin
          next_ring_cnt = ring_cnt + 16'(ring_tick);
          if (base_tick) begin
            if (win_cnt == icst_pkg::MEAS_LAST_PERIOD) begin
              next_meas  = ring_cnt + 16'(ring_tick);
              next_state = icst_pkg::FLT_CORRECT;
            end else begin
              next_win_cnt = win_cnt + 2'h1;
            end
          end
        end
      end
      icst_pkg::FLT_CORRECT: begin
        next_band     = meas_band;
        next_win_cnt  = '0;
        next_ring_cnt = '0;
        next_state    = cfg.gen_on ? icst_pkg::FLT_MEASURE : icst_pkg::FLT_IDLE;
      end
      default: begin
        next_state = icst_pkg::FLT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state    <= icst_pkg::FLT_IDLE;
      win_cnt  <= '0;
      ring_cnt <= '0;
      meas     <= '0;
      band     <= icst_pkg::BAND_COARSE;
    end else begin
      state    <= next_state;
      win_cnt  <= next_win_cnt;
      ring_cnt <= next_ring_cnt;
      meas     <= next_meas;
      band     <= next_band;
    end
  end

  // software registers, dco owned by software while off and by the filter while on
  always_comb begin
    next_cfg    = cfg;
    next_dco    = dco;
    next_stable = stable;
    if (wr_en) begin
      case (paddr)
        icst_pkg::ADDR_CTRL:  next_cfg.gen_on = pwdata[0];
        icst_pkg::ADDR_MULT:  next_cfg.mult   = pwdata[6:0];
        icst_pkg::ADDR_TRIM:  next_cfg.trim   = pwdata[7:0];
        icst_pkg::ADDR_DIV: begin
          if (!cfg.gen_on) begin
            next_dco.div = pwdata[3:0];
          end
        end
        icst_pkg::ADDR_STAGE: begin
          if (!cfg.gen_on) begin
            next_dco.stage = pwdata[7:0];
          end
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
    // one correction per window, direction from the sign of the error
    // gated by run so that a correction due in a stop cycle is dropped, not applied later
    if (state == icst_pkg::FLT_CORRECT && run && err != '0) begin
      next_dco = dco_step(dco, step, too_fast);
    end
    if (state == icst_pkg::FLT_CORRECT && run && meas_band == icst_pkg::BAND_MIN) begin
      next_stable = 1'b1;
    end
    // forced clears take priority over a set in the same cycle
    if (wr_mult || !cfg.gen_on) begin
      next_stable = 1'b0;
    end
  end

  // register contents depend only on reset, never on stop
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg.gen_on <= 1'b1;
      cfg.mult   <= icst_pkg::MULT_RESET;
      cfg.trim   <= icst_pkg::TRIM_RESET;
      dco.div    <= icst_pkg::DIV_RESET;
      dco.stage  <= icst_pkg::STAGE_RESET;
      stable     <= 1'b0;
    end else begin
      cfg    <= next_cfg;
      dco    <= next_dco;
      stable <= next_stable;
    end
  end

  // bus clock: ring clock divided by four, low whenever the ring is stopped
  always_comb begin
    next_bus_cnt = bus_cnt;
    next_bus_lvl = bus_lvl;
    if (!run) begin
      next_bus_cnt = '0;
      next_bus_lvl = 1'b0;
    end else if (ring_tick) begin
      next_bus_cnt = bus_cnt + 2'h1;
      if (bus_cnt == icst_pkg::BUS_TOGGLE_LAST) begin
        next_bus_lvl = ~bus_lvl;
      end
    end
  end

  // read data captured in the setup phase so it is a flop in the access phase
  always_comb begin
    next_rdata = rdata;
    if (rd_setup) begin
      case (paddr)
        icst_pkg::ADDR_CTRL:   next_rdata = {31'h0, cfg.gen_on};
        icst_pkg::ADDR_MULT:   next_rdata = {25'h0, cfg.mult};
        icst_pkg::ADDR_TRIM:   next_rdata = {24'h0, cfg.trim};
        icst_pkg::ADDR_DIV:    next_rdata = {28'h0, dco.div};
        icst_pkg::ADDR_STAGE:  next_rdata = {24'h0, dco.stage};
        icst_pkg::ADDR_STATUS: next_rdata = {27'h0, stop_mode, wait_mode, band, stable};
        icst_pkg::ADDR_MEAS:   next_rdata = {16'h0, meas};
        default:               next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus_cnt <= '0;
      bus_lvl <= 1'b0;
      rdata   <= 32'h0;
    end else begin
      bus_cnt <= next_bus_cnt;
      bus_lvl <= next_bus_lvl;
      rdata   <= next_rdata;
    end
  end

  // no external source in this block, so the selected clock is the ring clock
  assign ring_clock          = ring_lvl;
  assign selected_osc_output = ring_lvl;
  assign bus_clock_output    = bus_lvl;
  assign clock_stable_flag   = stable;
  assign prdata              = rdata;

endmodule : icst_clock_gen

// [sim/icst_clock_gen_properties.sv]
`timescale 1ns/1ps
module icst_clock_gen_properties #(
  parameter logic [17:0] RING_UNIT = 18'h00020
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        stop_mode,
  input wire logic        wait_mode,
  input wire logic        ring_clock,
  input wire logic        selected_osc_output,
  input wire logic        bus_clock_output,
  input wire logic        clock_stable_flag
);
  // single domain, reset silences every check
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // bus phases and quiet stop stretches
  sequence s_mult_wr;
    psel && penable && pwrite && paddr == icst_pkg::ADDR_MULT;
  endsequence
  sequence s_off_wr;
    psel && penable && pwrite && paddr == icst_pkg::ADDR_CTRL && !pwdata[0];
  endsequence
  sequence s_status_setup;
    psel && !penable && !pwrite && paddr == icst_pkg::ADDR_STATUS;
  endsequence
  sequence s_quiet_stop;
    (stop_mode && !(psel && pwrite))[*3];
  endsequence

  mult_clear_a: assert property (s_mult_wr |=> !clock_stable_flag)
    else $error("stable flag survived a multiply write");
  off_clear_a: assert property (s_off_wr |=> ##1 (!clock_stable_flag && !ring_clock))
    else $error("generator off but flag or ring still active");
  stop_low_a: assert property (stop_mode |=> !ring_clock && !bus_clock_output)
    else $error("clock output not low in stop");
  stop_hold_a: assert property (s_quiet_stop |-> $stable(clock_stable_flag))
    else $error("stable flag moved during stop");
  osc_same_a: assert property (selected_osc_output == ring_clock)
    else $error("selected output differs from ring clock");
  status_read_a: assert property (s_status_setup |=> prdata[0] == $past(clock_stable_flag)
    && prdata[3] == $past(wait_mode) && prdata[4] == $past(stop_mode))
    else $error("status read does not match flag or modes");
  err_map_a: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > icst_pkg::ADDR_MEAS))
    else $error("slave error does not match the address map");
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule : icst_clock_gen_properties

bind icst_clock_gen icst_clock_gen_properties #(.RING_UNIT(RING_UNIT)) u_props (
  .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_mode(stop_mode), .wait_mode(wait_mode), .ring_clock(ring_clock),
  .selected_osc_output(selected_osc_output), .bus_clock_output(bus_clock_output),
  .clock_stable_flag(clock_stable_flag));

// [sim/icst_clock_gen_bench.sv]
`timescale 1ns/1ps
module icst_clock_gen_bench;
  // ring unit chosen so the reset point sits near the 0x15 target
  localparam logic [17:0] RING_UNIT_TB = 18'h00053;
  logic        clk_sys;
  logic        resetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stop_mode;
  logic        wait_mode;
  logic        ring_clock;
  logic        selected_osc_output;
  logic        bus_clock_output;
  logic        clock_stable_flag;
  int          n_errors;
  int          check_count;
  int          ring_rises;
  int          bus_rises;
  int          r0;
  int          b0;
  logic        ring_q;
  logic        bus_q;
  logic        err_seen;
  logic [31:0] rd;
  logic [31:0] m0;
  logic [31:0] sv_div;
  logic [31:0] sv_stage;

  icst_clock_gen #(.RING_UNIT(RING_UNIT_TB)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .ring_clock(ring_clock),
    .selected_osc_output(selected_osc_output), .bus_clock_output(bus_clock_output),
    .clock_stable_flag(clock_stable_flag));

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // rising edges of the generated clocks, sampled at the system clock
  always @(posedge clk_sys) begin
    ring_q <= ring_clock;
    bus_q <= bus_clock_output;
    if (ring_clock === 1'b1 && ring_q === 1'b0) ring_rises++;
    if (bus_clock_output === 1'b1 && bus_q === 1'b0) bus_rises++;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : check

  // one bus transfer; request held until ready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check("pready", 32'h1, {31'h0, pready});
      stop_test();
    end
    @(posedge clk_sys);
  endtask : xfer

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] mk,
                      input logic [31:0] ex);
    xfer(a, 1'b0, 32'h0);
    check(nm, ex, rd & mk);
  endtask : rchk

  // bounded wait for the stable flag
  task automatic wait_flag(input int bound);
    int n;
    n = 0;
    while (clock_stable_flag !== 1'b1 && n < bound) begin
      @(posedge clk_sys);
      n++;
    end
    check("flag", 32'h1, {31'h0, clock_stable_flag});
    if (clock_stable_flag !== 1'b1) stop_test();
  endtask : wait_flag

  initial begin
    resetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    stop_mode = 1'b0;
    wait_mode = 1'b0;
    ring_q = 1'b0;
    bus_q = 1'b0;
    n_errors = 0;
    check_count = 0;
    ring_rises = 0;
    bus_rises = 0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    // reset values, reserved bits zero, unmapped place
    rchk("ctrl", icst_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
    rchk("mult", icst_pkg::ADDR_MULT, 32'hFFFFFFFF, 32'h15);
    rchk("trim", icst_pkg::ADDR_TRIM, 32'hFFFFFFFF, 32'h80);
    rchk("div", icst_pkg::ADDR_DIV, 32'hFFFFFFFF, 32'h0);
    rchk("stage", icst_pkg::ADDR_STAGE, 32'hFFFFFFFF, 32'h80);
    rchk("flag", icst_pkg::ADDR_STATUS, 32'h1, 32'h0);
    rchk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
    check("slverr", 32'h1, {31'h0, err_seen});
    // settle, then medium and coarse bands after multiply changes
    wait_flag(20000);
    rchk("band min", icst_pkg::ADDR_STATUS, 32'h6, 32'h0);
    xfer(icst_pkg::ADDR_MULT, 1'b1, 32'h17);
    rchk("flag cleared", icst_pkg::ADDR_STATUS, 32'h1, 32'h0);
    repeat (400) @(posedge clk_sys);
    rchk("band medium", icst_pkg::ADDR_STATUS, 32'h6, 32'h2);
    wait_flag(3000);
    xfer(icst_pkg::ADDR_MULT, 1'b1, 32'h0B);
    repeat (400) @(posedge clk_sys);
    rchk("band coarse", icst_pkg::ADDR_STATUS, 32'h6, 32'h4);
    wait_flag(12000);
    // larger trim slows the base clock, so more ring counts
    xfer(icst_pkg::ADDR_MEAS, 1'b0, 32'h0);
    m0 = rd;
    xfer(icst_pkg::ADDR_TRIM, 1'b1, 32'hA0);
    repeat (400) @(posedge clk_sys);
    xfer(icst_pkg::ADDR_MEAS, 1'b0, 32'h0);
    check("meas grows", 32'h1, {31'h0, rd[15:0] * 100 > m0[15:0] * 103});
    xfer(icst_pkg::ADDR_TRIM, 1'b1, 32'h1FF);
    rchk("trim top", icst_pkg::ADDR_TRIM, 32'hFFFFFFFF, 32'hFF);
    // restore the reset trim value
    xfer(icst_pkg::ADDR_TRIM, 1'b1, 32'h80);
    // bus clock runs at a quarter of the ring clock
    r0 = ring_rises;
    b0 = bus_rises;
    repeat (800) @(posedge clk_sys);
    check("bus ratio", 32'h1, {31'h0, bus_rises > b0
      && ((ring_rises - r0) - 4 * (bus_rises - b0)) inside {[-4:4]}});
    // divider and stage preload only while the generator is off
    xfer(icst_pkg::ADDR_DIV, 1'b0, 32'h0);
    sv_div = rd;
    xfer(icst_pkg::ADDR_DIV, 1'b1, 32'h5);
    rchk("div gated", icst_pkg::ADDR_DIV, 32'hF, sv_div);
    xfer(icst_pkg::ADDR_CTRL, 1'b1, 32'h0);
    xfer(icst_pkg::ADDR_DIV, 1'b1, 32'hC);
    rchk("div raw", icst_pkg::ADDR_DIV, 32'hFFFFFFFF, 32'hC);
    // software scales by powers of two on the divider, stage kept within 255
    xfer(icst_pkg::ADDR_DIV, 1'b1, 32'h4);
    r0 = ring_rises;
    xfer(icst_pkg::ADDR_STAGE, 1'b1, 32'h90);
    rchk("div off", icst_pkg::ADDR_DIV, 32'hF, 32'h4);
    rchk("stage off", icst_pkg::ADDR_STAGE, 32'hFF, 32'h90);
    check("ring idle", 32'h0, 32'(ring_rises - r0));
    xfer(icst_pkg::ADDR_CTRL, 1'b1, 32'h1);
    rchk("div restart", icst_pkg::ADDR_DIV, 32'hF, 32'h4);
    rchk("stage restart", icst_pkg::ADDR_STAGE, 32'hFF, 32'h90);
    // period 0x90 << 4 over the ring unit gives about 9 ticks a window
    repeat (400) @(posedge clk_sys);
    xfer(icst_pkg::ADDR_MEAS, 1'b0, 32'h0);
    check("meas point", 32'h1, {31'h0, rd[15:0] inside {[16'h8:16'hA]}});
    // wait mode keeps the ring running
    wait_mode <= 1'b1;
    r0 = ring_rises;
    repeat (200) @(posedge clk_sys);
    check("ring in wait", 32'h1, {31'h0, ring_rises > r0});
    rchk("wait status", icst_pkg::ADDR_STATUS, 32'h8, 32'h8);
    wait_mode <= 1'b0;
    // stop halts the ring and keeps the registers
    stop_mode <= 1'b1;
    xfer(icst_pkg::ADDR_STAGE, 1'b0, 32'h0);
    sv_stage = rd;
    xfer(icst_pkg::ADDR_DIV, 1'b0, 32'h0);
    sv_div = rd;
    r0 = ring_rises;
    repeat (300) @(posedge clk_sys);
    check("ring stopped", 32'h0, 32'(ring_rises - r0));
    rchk("stop status", icst_pkg::ADDR_STATUS, 32'h10, 32'h10);
    rchk("stage held", icst_pkg::ADDR_STAGE, 32'hFF, sv_stage);
    rchk("div held", icst_pkg::ADDR_DIV, 32'hF, sv_div);
    stop_mode <= 1'b0;
    rchk("mult held", icst_pkg::ADDR_MULT, 32'h7F, 32'h0B);
    rchk("trim held", icst_pkg::ADDR_TRIM, 32'hFF, 32'h80);
    stop_test();
  end
endmodule : icst_clock_gen_bench
